// File: rtl/msc_control_regs.sv
// Behaviour
// - X rate bytes readable at 0x43/0x44
// - Y rate bytes readable at 0x45/0x46
// - Z rate bytes readable at 0x47/0x48
// - Rate path reset keeps stored results
// - Acceleration path reset, results kept
// - Temperature path reset, results kept
// - Compare enable bit gates motion logic
// - Mode one compares with previous sample
// - Mode zero compares with first sample
// - Run bit; halt after current sample
// - Runs with sensors off, except 8 kHz
// - FIFO bit gates serial FIFO access
// - Bit four resets serial slave
// - Bit three resets processor, self-clears
// - Bit two resets FIFO, self-clears
// - Bit zero resets paths, clears results
// - Conditioning reset lasts one 8 MHz period
// - Motion per axis sets status bit
`timescale 1ns/1ps
module msc_control_regs (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [6:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [15:0] rate_x,
	input  wire logic [15:0] rate_y,
	input  wire logic [15:0] rate_z,
	input  wire logic        rate_valid,
	input  wire logic [15:0] accel_x,
	input  wire logic [15:0] accel_y,
	input  wire logic [15:0] accel_z,
	input  wire logic        accel_valid,
	input  wire logic [7:0]  wom_threshold,
	input  wire logic [2:0]  wake_on_motion_clear,
	output logic      [2:0]  wake_on_motion_status,
	input  wire logic        mp_busy,
	input  wire logic        sample_rate_8k,
	input  wire logic        sensors_all_off,
	output logic             motion_proc_run,
	output logic             fifo_serial_access,
	output logic             serial_slave_reset,
	output logic             motion_proc_reset,
	output logic             fifo_reset,
	output logic             full_conditioning_reset,
	output logic             rate_path_reset,
	output logic             accel_path_reset,
	output logic             temp_path_reset
);
	import msc_pkg::*;

	logic [15:0] rate_x_ff;
	logic [15:0] rate_y_ff;
	logic [15:0] rate_z_ff;
	logic [15:0] nxt_rate_x;
	logic [15:0] nxt_rate_y;
	logic [15:0] nxt_rate_z;
	logic [7:0]  mcmp_ff;
	logic [7:0]  nxt_mcmp;
	logic [7:0]  hctl_ff;
	logic [7:0]  nxt_hctl;
	logic [2:0]  path_rst_ff;
	logic [2:0]  nxt_path_rst;
	logic [2:0]  wom_status_ff;
	logic [2:0]  nxt_wom_status;
	logic [2:0]  wom_det;
	logic        run_ff;
	logic        nxt_run;
	logic [7:0]  rdata_ff;
	logic [7:0]  nxt_rdata;
	logic        cond_pulse;
	logic        rate_hold;

	function automatic logic wr_hit(input logic wr, input logic [6:0] a, input logic [6:0] t);
		wr_hit = wr && (a == t);
	endfunction

	// Stretches the one-cycle request to one 8 MHz period
	msc_pulse_stretch #(
		.LEN (COND_RST_CYCLES)
	) u_cond_pulse (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.trig     (hctl_ff[HCTL_COND_RST_BIT]),
		.pulse_ff (cond_pulse)
	);

	msc_wom_axis u_wom_x (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.sample       (accel_x),
		.sample_valid (accel_valid),
		.enable       (mcmp_ff[MCMP_ENABLE_BIT]),
		.mode_prev    (mcmp_ff[MCMP_MODE_BIT]),
		.flush        (path_rst_ff[PRST_ACCEL_BIT]),
		.threshold    (wom_threshold),
		.motion_ff    (wom_det[2])
	);

	msc_wom_axis u_wom_y (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.sample       (accel_y),
		.sample_valid (accel_valid),
		.enable       (mcmp_ff[MCMP_ENABLE_BIT]),
		.mode_prev    (mcmp_ff[MCMP_MODE_BIT]),
		.flush        (path_rst_ff[PRST_ACCEL_BIT]),
		.threshold    (wom_threshold),
		.motion_ff    (wom_det[1])
	);

	msc_wom_axis u_wom_z (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.sample       (accel_z),
		.sample_valid (accel_valid),
		.enable       (mcmp_ff[MCMP_ENABLE_BIT]),
		.mode_prev    (mcmp_ff[MCMP_MODE_BIT]),
		.flush        (path_rst_ff[PRST_ACCEL_BIT]),
		.threshold    (wom_threshold),
		.motion_ff    (wom_det[0])
	);

	// Control registers and self-clearing strobes
	always_comb begin
		nxt_mcmp = mcmp_ff;
		if (wr_hit(reg_wr, reg_addr, ADDR_MOTION_COMPARE)) begin
			nxt_mcmp = reg_wdata & MCMP_WR_MASK;
		end
		// Strobe bits drop after one cycle; only the two enables persist
		nxt_hctl = hctl_ff & HCTL_KEEP_MASK;
		if (wr_hit(reg_wr, reg_addr, ADDR_HOST_CONTROL)) begin
			nxt_hctl = reg_wdata & HCTL_WR_MASK;
		end
		nxt_path_rst = 3'h0;
		if (wr_hit(reg_wr, reg_addr, ADDR_PATH_RESET_CTL)) begin
			nxt_path_rst = reg_wdata[2:0];
		end
		nxt_path_rst = nxt_path_rst | {3{cond_pulse}};
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mcmp_ff     <= MCMP_RESET;
			hctl_ff     <= HCTL_RESET;
			path_rst_ff <= 3'h0;
		end else begin
			mcmp_ff     <= nxt_mcmp;
			hctl_ff     <= nxt_hctl;
			path_rst_ff <= nxt_path_rst;
		end
	end

	// Rate results: all three axes load in one edge so byte pairs match
	assign rate_hold = path_rst_ff[PRST_RATE_BIT] | cond_pulse;

	always_comb begin
		nxt_rate_x = rate_x_ff;
		nxt_rate_y = rate_y_ff;
		nxt_rate_z = rate_z_ff;
		if (hctl_ff[HCTL_COND_RST_BIT]) begin
			nxt_rate_x = RATE_RESET;
			nxt_rate_y = RATE_RESET;
			nxt_rate_z = RATE_RESET;
		end else if (rate_valid && !rate_hold) begin
			nxt_rate_x = rate_x;
			nxt_rate_y = rate_y;
			nxt_rate_z = rate_z;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rate_x_ff <= RATE_RESET;
			rate_y_ff <= RATE_RESET;
			rate_z_ff <= RATE_RESET;
		end else begin
			rate_x_ff <= nxt_rate_x;
			rate_y_ff <= nxt_rate_y;
			rate_z_ff <= nxt_rate_z;
		end
	end

	// Status flags: a detection in the clearing cycle survives
	always_comb begin
		nxt_wom_status = (wom_status_ff & ~wake_on_motion_clear) | wom_det;
	end

	// Processor keeps going until the sample in flight completes
	always_comb begin
		nxt_run = (hctl_ff[HCTL_MP_EN_BIT] && !(sample_rate_8k && sensors_all_off))
			|| (run_ff && mp_busy);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wom_status_ff <= 3'h0;
			run_ff        <= 1'b0;
		end else begin
			wom_status_ff <= nxt_wom_status;
			run_ff        <= nxt_run;
		end
	end

	// Read data registered one cycle after the read strobe
	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_RATE_X_HIGH:    nxt_rdata = rate_x_ff[15:8];
				ADDR_RATE_X_LOW:     nxt_rdata = rate_x_ff[7:0];
				ADDR_RATE_Y_HIGH:    nxt_rdata = rate_y_ff[15:8];
				ADDR_RATE_Y_LOW:     nxt_rdata = rate_y_ff[7:0];
				ADDR_RATE_Z_HIGH:    nxt_rdata = rate_z_ff[15:8];
				ADDR_RATE_Z_LOW:     nxt_rdata = rate_z_ff[7:0];
				ADDR_MOTION_COMPARE: nxt_rdata = mcmp_ff;
				ADDR_HOST_CONTROL:   nxt_rdata = hctl_ff;
				default:             nxt_rdata = RDATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_ff <= RDATA_ZERO;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata               = rdata_ff;
	assign wake_on_motion_status   = wom_status_ff;
	assign motion_proc_run         = run_ff;
	assign fifo_serial_access      = hctl_ff[HCTL_FIFO_EN_BIT];
	assign serial_slave_reset      = hctl_ff[HCTL_SLAVE_RST_BIT];
	assign motion_proc_reset       = hctl_ff[HCTL_MP_RST_BIT];
	assign fifo_reset              = hctl_ff[HCTL_FIFO_RST_BIT];
	assign full_conditioning_reset = cond_pulse;
	assign rate_path_reset         = path_rst_ff[PRST_RATE_BIT];
	assign accel_path_reset        = path_rst_ff[PRST_ACCEL_BIT];
	assign temp_path_reset         = path_rst_ff[PRST_TEMP_BIT];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	x_read_a: assert property (
		reg_rd && reg_addr == ADDR_RATE_X_LOW |=> reg_rdata == $past(rate_x_ff[7:0]))
		else $error("x low byte read wrong");

	y_pair_a: assert property (
		rate_valid && !rate_hold && !hctl_ff[0] |=> rate_y_ff == $past(rate_y))
		else $error("y rate not captured");

	z_high_a: assert property (
		reg_rd && reg_addr == ADDR_RATE_Z_HIGH |=> reg_rdata == $past(rate_z_ff[15:8]))
		else $error("z high byte read wrong");

	rate_keep_a: assert property (
		reg_wr && reg_addr == ADDR_PATH_RESET_CTL && reg_wdata[2] && !hctl_ff[0]
		|=> rate_path_reset ##1 $stable(rate_x_ff))
		else $error("rate path reset disturbed results");

	accel_rst_a: assert property (
		reg_wr && reg_addr == ADDR_PATH_RESET_CTL && reg_wdata[1] |=> accel_path_reset)
		else $error("accel path reset missing");

	temp_rst_a: assert property (
		reg_wr && reg_addr == ADDR_PATH_RESET_CTL && reg_wdata[0] |=> temp_path_reset)
		else $error("temp path reset missing");

	wom_off_a: assert property (
		!mcmp_ff[MCMP_ENABLE_BIT] |=> wom_det == 3'h0)
		else $error("motion detected while disabled");

	run_halt_a: assert property (
		!hctl_ff[HCTL_MP_EN_BIT] && !mp_busy |=> !motion_proc_run)
		else $error("processor failed to halt");

	run_on_a: assert property (
		hctl_ff[HCTL_MP_EN_BIT] && !(sample_rate_8k && sensors_all_off) |=> motion_proc_run)
		else $error("processor not running");

	fifo_gate_a: assert property (
		reg_wr && reg_addr == ADDR_HOST_CONTROL |=> fifo_serial_access == $past(reg_wdata[6]))
		else $error("fifo access bit wrong");

	slave_rst_a: assert property (
		reg_wr && reg_addr == ADDR_HOST_CONTROL && reg_wdata[4] |=> serial_slave_reset)
		else $error("serial slave reset missing");

	mp_rst_a: assert property (
		reg_wr && reg_addr == ADDR_HOST_CONTROL && reg_wdata[3]
		##1 !(reg_wr && reg_addr == ADDR_HOST_CONTROL)
		|-> motion_proc_reset ##1 !motion_proc_reset)
		else $error("processor reset not self clearing");

	fifo_rst_a: assert property (
		reg_wr && reg_addr == ADDR_HOST_CONTROL && reg_wdata[2]
		##1 !(reg_wr && reg_addr == ADDR_HOST_CONTROL)
		|-> fifo_reset ##1 !fifo_reset)
		else $error("fifo reset not self clearing");

	cond_clear_a: assert property (
		hctl_ff[HCTL_COND_RST_BIT] |=> rate_x_ff == 16'h0000 && full_conditioning_reset)
		else $error("results not cleared");

	status_set_a: assert property (
		wom_det[2] |=> wake_on_motion_status[2])
		else $error("x motion flag not set");

	reserved_zero_a: assert property (
		reg_rd && reg_addr == ADDR_MOTION_COMPARE |=> reg_rdata[5:0] == 6'h00)
		else $error("reserved bits not zero");

	rate_cap_c: cover property (rate_valid ##1 reg_rd && reg_addr == ADDR_RATE_X_HIGH);
	cond_rst_c: cover property ($fell(full_conditioning_reset));
	wom_hit_c:  cover property (|wom_det);
	halt_c:     cover property ($fell(motion_proc_run));

endmodule

// File: rtl/msc_pkg.sv
package msc_pkg;

	// Byte register offsets
	localparam logic [6:0] ADDR_RATE_X_HIGH      = 7'h43;
	localparam logic [6:0] ADDR_RATE_X_LOW       = 7'h44;
	localparam logic [6:0] ADDR_RATE_Y_HIGH      = 7'h45;
	localparam logic [6:0] ADDR_RATE_Y_LOW       = 7'h46;
	localparam logic [6:0] ADDR_RATE_Z_HIGH      = 7'h47;
	localparam logic [6:0] ADDR_RATE_Z_LOW       = 7'h48;
	localparam logic [6:0] ADDR_PATH_RESET_CTL   = 7'h68;
	localparam logic [6:0] ADDR_MOTION_COMPARE   = 7'h69;
	localparam logic [6:0] ADDR_HOST_CONTROL     = 7'h6A;

	// Path reset control fields
	localparam int PRST_RATE_BIT  = 2;
	localparam int PRST_ACCEL_BIT = 1;
	localparam int PRST_TEMP_BIT  = 0;

	// Motion compare control fields
	localparam int                MCMP_ENABLE_BIT = 7;
	localparam int                MCMP_MODE_BIT   = 6;
	localparam logic [7:0]        MCMP_WR_MASK    = 8'hC0;
	localparam logic [7:0]        MCMP_RESET      = 8'h00;

	// Host control fields
	localparam int                HCTL_MP_EN_BIT     = 7;
	localparam int                HCTL_FIFO_EN_BIT   = 6;
	localparam int                HCTL_SLAVE_RST_BIT = 4;
	localparam int                HCTL_MP_RST_BIT    = 3;
	localparam int                HCTL_FIFO_RST_BIT  = 2;
	localparam int                HCTL_COND_RST_BIT  = 0;
	localparam logic [7:0]        HCTL_WR_MASK       = 8'hDD;
	localparam logic [7:0]        HCTL_KEEP_MASK     = 8'hC0;
	localparam logic [7:0]        HCTL_RESET         = 8'h00;

	localparam logic [15:0]       RATE_RESET = 16'h0000;
	localparam logic [7:0]        RDATA_ZERO = 8'h00;

	// Conditioning reset width: one 8 MHz period, rounded up to clk_sys cycles
	localparam int CLK_SYS_PERIOD_NS = 100;
	localparam int COND_RST_NS       = 125;
	localparam int COND_RST_CYCLES   =
		(COND_RST_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;

	typedef enum {
		WOM_NOREF,
		WOM_ARMED
	} msc_wom_state_type;

	// Magnitude of the difference of two signed samples
	function automatic logic [16:0] msc_abs_diff(input logic [15:0] a, input logic [15:0] b);
		logic signed [16:0] d;
		d = $signed({a[15], a}) - $signed({b[15], b});
		msc_abs_diff = d[16] ? 17'(-d) : 17'(d);
	endfunction

endpackage

// File: rtl/msc_pulse_stretch.sv
`timescale 1ns/1ps
module msc_pulse_stretch #(
	parameter int LEN = 2
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic trig,
	output logic      pulse_ff
);
	import msc_pkg::*;

	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic       nxt_pulse;
	logic [3:0] run_cnt_ff;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (trig) begin
			nxt_cnt = 4'(LEN);
		end else if (cnt_ff != 4'h0) begin
			nxt_cnt = cnt_ff - 4'h1;
		end
		nxt_pulse = (nxt_cnt != 4'h0);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_ff   <= 4'h0;
			pulse_ff <= 1'b0;
		end else begin
			cnt_ff   <= nxt_cnt;
			pulse_ff <= nxt_pulse;
		end
	end

	// Helper: length of the last high run
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			run_cnt_ff <= 4'h0;
		end else if (pulse_ff) begin
			run_cnt_ff <= run_cnt_ff + 4'h1;
		end else begin
			run_cnt_ff <= 4'h0;
		end
	end

	pulse_width_a: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(pulse_ff) |-> run_cnt_ff == 4'(LEN))
		else $error("conditioning pulse width wrong");

endmodule

// File: rtl/msc_wom_axis.sv
`timescale 1ns/1ps
module msc_wom_axis (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [15:0] sample,
	input  wire logic        sample_valid,
	input  wire logic        enable,
	input  wire logic        mode_prev,
	input  wire logic        flush,
	input  wire logic [7:0]  threshold,
	output logic             motion_ff
);
	import msc_pkg::*;

	msc_wom_state_type state_ff;
	msc_wom_state_type nxt_state;
	logic [15:0]       ref_ff;
	logic [15:0]       nxt_ref;
	logic              nxt_motion;

	always_comb begin
		nxt_state  = state_ff;
		nxt_ref    = ref_ff;
		nxt_motion = 1'b0;
		if (!enable || flush) begin
			nxt_state = WOM_NOREF;
		end else if (sample_valid) begin
			case (state_ff)
				WOM_NOREF: begin
					nxt_ref   = sample;
					nxt_state = WOM_ARMED;
				end
				WOM_ARMED: begin
					nxt_motion = msc_abs_diff(sample, ref_ff) > {9'h000, threshold};
					if (mode_prev) begin
						nxt_ref = sample;
					end
				end
				default: nxt_state = WOM_NOREF;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff  <= WOM_NOREF;
			ref_ff    <= 16'h0000;
			motion_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			ref_ff    <= nxt_ref;
			motion_ff <= nxt_motion;
		end
	end

	ref_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
		enable && !flush && sample_valid && mode_prev |=> ref_ff == $past(sample))
		else $error("reference did not follow previous sample");

	ref_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		state_ff == WOM_ARMED && enable && !flush && !mode_prev |=> $stable(ref_ff))
		else $error("fixed reference changed");

endmodule

// File: verif/msc_host_model.sv
`timescale 1ns/1ps
module msc_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic      [6:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd
);
	initial begin
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask

	// Idle lines are scrambled so a stale address or data cannot pass
	task automatic release_bus();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask

	task automatic write(input logic [6:0] a, input logic [7:0] d);
		step();
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		release_bus();
	endtask

	task automatic read(input logic [6:0] a, output logic [7:0] d);
		step();
		reg_addr = a;
		reg_rd = 1'b1;
		step();
		release_bus();
		step();
		d = reg_rdata;
	endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
	import msc_pkg::*;
	logic        clk_sys, rst, reg_wr, reg_rd, rate_valid, accel_valid;
	logic        mp_busy, sample_rate_8k, sensors_all_off, motion_proc_run, fifo_serial_access;
	logic        serial_slave_reset, motion_proc_reset, fifo_reset, full_conditioning_reset;
	logic        rate_path_reset, accel_path_reset, temp_path_reset;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, wom_threshold, rd;
	logic [15:0] rate_x, rate_y, rate_z, accel_x, accel_y, accel_z, exp_rate[3];
	logic [2:0]  wake_on_motion_clear, wake_on_motion_status, want3;
	logic [6:0]  ta[7] = '{ADDR_PATH_RESET_CTL, ADDR_PATH_RESET_CTL, ADDR_PATH_RESET_CTL,
		ADDR_HOST_CONTROL, ADDR_HOST_CONTROL, ADDR_HOST_CONTROL, ADDR_HOST_CONTROL};
	int          tbit[7] = '{2, 1, 0, 4, 3, 2, 0};
	int          failures, num_checks, thr, cnt[7], cur[3], prev[3], first[3], off[4], want;
	wire  [6:0]  pulse_vec = {serial_slave_reset, motion_proc_reset, fifo_reset,
		full_conditioning_reset, rate_path_reset, accel_path_reset, temp_path_reset};

	msc_control_regs dut (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.rate_x, .rate_y, .rate_z, .rate_valid, .accel_x, .accel_y, .accel_z, .accel_valid,
		.wom_threshold, .wake_on_motion_clear, .wake_on_motion_status, .mp_busy,
		.sample_rate_8k, .sensors_all_off, .motion_proc_run, .fifo_serial_access,
		.serial_slave_reset, .motion_proc_reset, .fifo_reset, .full_conditioning_reset,
		.rate_path_reset, .accel_path_reset, .temp_path_reset);
	msc_host_model host (.clk_sys, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		host.read(a, rd);
		chk(rd, exp);
	endtask

	task automatic load_rate();
		for (int i = 0; i < 3; i++) exp_rate[i] = 16'($urandom);
		step();
		{rate_x, rate_y, rate_z} = {exp_rate[0], exp_rate[1], exp_rate[2]};
		rate_valid = 1'b1;
		step();
		rate_valid = 1'b0;
		{rate_x, rate_y, rate_z} = ~{rate_x, rate_y, rate_z};
	endtask

	task automatic rd_rates(input logic clr);
		logic [15:0] v;
		for (int i = 0; i < 3; i++) begin
			v = clr ? 16'h0000 : exp_rate[i];
			rd_chk(7'(ADDR_RATE_X_HIGH + 2 * i), v[15:8]);
			rd_chk(7'(ADDR_RATE_X_LOW + 2 * i), v[7:0]);
		end
	endtask

	task automatic acc();
		step();
		{accel_x, accel_y, accel_z} = {16'(cur[0]), 16'(cur[1]), 16'(cur[2])};
		accel_valid = 1'b1;
		step();
		accel_valid = 1'b0;
		{accel_x, accel_y, accel_z} = ~{accel_x, accel_y, accel_z};
	endtask

	// Pulse count per output index: 0 slave, 1 processor, 2 fifo, 3 cond, 4..6 paths
	function automatic int exp_cnt(input logic [6:0] a, input int b, input int s);
		if (a == ADDR_PATH_RESET_CTL) return (s == 6 - b) ? 1 : 0;
		if (b == 0) return (s >= 3) ? COND_RST_CYCLES : 0;
		return (s == 4 - b) ? 1 : 0;
	endfunction

	// Mode one compares with the previous sample, mode zero with the stored first one
	function automatic logic [2:0] exp_flags(input int c[3], input int p[3], input int f[3],
		input int m, input int t);
		int r;
		for (int i = 0; i < 3; i++) begin
			r = (m == 1) ? p[i] : f[i];
			exp_flags[2 - i] = ((c[i] > r) ? c[i] - r : r - c[i]) > t;
		end
	endfunction

	task automatic report_and_stop();
		if (failures == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#2_000_000;
		failures++;
		report_and_stop();
	end

	initial begin
		{rst, rate_valid, accel_valid, mp_busy, sample_rate_8k, sensors_all_off} = 6'h20;
		{rate_x, rate_y, rate_z, accel_x, accel_y, accel_z} = '0;
		wake_on_motion_clear = 3'h0;
		wom_threshold = 8'h00;
		void'($urandom(32'hC18D));
		repeat (16) step();
		rst = 1'b0;
		rd_rates(1'b1);
		rd_chk(ADDR_HOST_CONTROL, 8'h00);
		rd_chk(7'h42, 8'h00);
		// Each reset strobe alone, counting every pulse output over a window
		for (int i = 0; i < 7; i++) begin
			load_rate();
			host.write(ta[i], 8'(1 << tbit[i]));
			for (int s = 0; s < 7; s++) cnt[s] = 0;
			repeat (8) begin
				for (int s = 0; s < 7; s++) cnt[s] += int'(pulse_vec[6 - s]);
				step();
			end
			for (int s = 0; s < 7; s++) begin
				want = exp_cnt(ta[i], tbit[i], s);
				chk(8'(cnt[s]), 8'(want));
			end
			rd_rates(ta[i] == ADDR_HOST_CONTROL && tbit[i] == 0);
		end
		rd_chk(ADDR_PATH_RESET_CTL, 8'h00);
		load_rate();
		host.write(ADDR_RATE_X_HIGH, ~exp_rate[0][15:8]);
		rd_rates(1'b0);
		host.write(ADDR_MOTION_COMPARE, 8'hFF);
		rd_chk(ADDR_MOTION_COMPARE, 8'hC0);
		host.write(ADDR_HOST_CONTROL, 8'h40);
		chk({fifo_serial_access, motion_proc_run}, 8'h02);
		host.write(ADDR_HOST_CONTROL, 8'hE2);
		rd_chk(ADDR_HOST_CONTROL, 8'hC0);
		sensors_all_off = 1'b1;
		step();
		chk({fifo_serial_access, motion_proc_run}, 8'h03);
		sample_rate_8k = 1'b1;
		step();
		step();
		chk(motion_proc_run, 8'h00);
		{sample_rate_8k, mp_busy} = 2'h1;
		step();
		step();
		host.write(ADDR_HOST_CONTROL, 8'h00);
		step();
		step();
		chk(motion_proc_run, 8'h01);
		mp_busy = 1'b0;
		step();
		step();
		chk(motion_proc_run, 8'h00);
		// Mode 0 fixed reference, mode 1 previous sample, pass 2 disabled
		thr = $urandom_range(1, 100);
		wom_threshold = 8'(thr);
		off = '{0, thr, thr + 1, -thr - 1};
		for (int m = 0; m < 3; m++) begin
			host.write(ADDR_MOTION_COMPARE, 8'h00);
			host.write(ADDR_MOTION_COMPARE, (m == 2) ? 8'h00 : 8'(8'h80 | (m << 6)));
			for (int k = 0; k < 8; k++) begin
				for (int a = 0; a < 3; a++) begin
					if (k == 0) first[a] = int'($urandom_range(0, 2000)) - 1000;
					if (k == 0) cur[a] = first[a];
					else if (k == 2) cur[a] = prev[a];
					else cur[a] = first[a] + off[$urandom_range(0, 3)];
				end
				step();
				wake_on_motion_clear = 3'h7;
				step();
				wake_on_motion_clear = 3'h0;
				// Accel path reset drops the reference; the next sample becomes it
				if (k == 4) host.write(ADDR_PATH_RESET_CTL, 8'h02);
				acc();
				step();
				step();
				want3 = (k == 0 || k == 4 || m == 2) ? 3'h0 : exp_flags(cur, prev, first, m, thr);
				chk(wake_on_motion_status, want3);
				if (k == 4) first = cur;
				prev = cur;
			end
		end
		report_and_stop();
	end
endmodule
